// [hdl/uart_ext_config_bit_mismatch_event.sv]
// Extended serial configuration, receive status and bit-error supervision.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
// How it works
// (RULE1) The receive-in-progress flag is set by hardware alone when a start bit is detected.
// (RULE2) The receive-in-progress flag clears when the stop condition ending the frame is seen.
// (RULE3) With tx abort enabled, a bit mismatch at once stops and resets transmit logic and FIFO.
// (RULE4) With loopback enabled, the transmit output is fed internally to the receive input.
// (RULE5) Software clears the matching pin function select while in loopback, keeping the pin quiet.
// (RULE6) With rx abort enabled, a bit mismatch at once stops and resets receive logic and FIFO.
// (RULE7) Writing one to the flush bit resets both FIFOs and state machines and then self-clears.
module uart_ext_config_bit_mismatch_event (
  input wire logic pclk,
  input wire logic presetn,
  input wire uart_ext_pkg::apb_req_t apb_req,
  output uart_ext_pkg::apb_rsp_t apb_rsp,
  input wire logic rx_pin,
  input wire logic tx_bit,
  input wire logic tx_check_valid,
  input wire logic tx_check_bit,
  input wire logic rx_start_det,
  input wire logic rx_stop_det,
  output logic rx_line,
  output logic tx_pin,
  output uart_ext_pkg::flush_ctl_t flush,
  output logic [7:0] line_config,
  output logic receive_in_progress,
  output logic irq
);
  import uart_ext_pkg::*;

  ctl_state_t state_reg;
  ctl_state_t state_next;
  logic rx_synced;
  logic bit_mismatch_event;
  logic setup_phase;
  logic write_done;
  logic [DATA_W-1:0] read_value;

  // Maps a register index to its byte address.
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] idx);
    byte_addr = {idx[ADDR_W-3:0], 2'b00};
  endfunction : byte_addr

  // Tells whether an address hits one of the block's registers.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
    addr_hit = (addr == byte_addr(LINE_CFG_IDX)) || (addr == byte_addr(EXT_CFG_IDX)) ||
               (addr == byte_addr(IRQ_STAT_IDX)) || (addr == byte_addr(IRQ_MASK_IDX));
  endfunction : addr_hit

  pin_sync u_rx_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(rx_pin),
    .pin_synced(rx_synced)
  );

  bit_checker u_checker (
    .pclk(pclk),
    .presetn(presetn),
    .check_valid(tx_check_valid),
    .expect_bit(tx_check_bit),
    .seen_bit(state_reg.rx_line),
    .mismatch(bit_mismatch_event)
  );

  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign write_done = apb_req.psel && apb_req.penable && apb_req.pwrite;

  // Builds the read word for the addressed register.
  always_comb begin
    read_value = '0;
    if (apb_req.paddr == byte_addr(LINE_CFG_IDX)) begin
      read_value[7:0] = state_reg.line_cfg;
    end else if (apb_req.paddr == byte_addr(EXT_CFG_IDX)) begin
      read_value[EXT_RX_BUSY] = (state_reg.rx_state == RX_ACTIVE);
      read_value[EXT_MISMATCH] = state_reg.ext.bit_mismatch_flag;
      read_value[EXT_TX_ABORT] = state_reg.ext.tx_abort_on_bit_error;
      read_value[EXT_RX_ABORT] = state_reg.ext.rx_abort_on_bit_error;
      read_value[EXT_LOOPBACK] = state_reg.ext.loopback_enable_bit;
      read_value[EXT_IRQ_EN] = state_reg.ext.bit_error_irq_enable;
      read_value[EXT_POLARITY] = state_reg.ext.tx_output_polarity;
    end else if (apb_req.paddr == byte_addr(IRQ_STAT_IDX)) begin
      read_value[IRQ_W-1:0] = state_reg.irq_status;
    end else if (apb_req.paddr == byte_addr(IRQ_MASK_IDX)) begin
      read_value[IRQ_W-1:0] = state_reg.irq_mask;
    end
  end

  // Abort requests act in the same cycle as the mismatch pulse.
  assign flush.tx_abort = (bit_mismatch_event && state_reg.ext.tx_abort_on_bit_error) ||
                          state_reg.ext.fifo_flush; // RULE3 RULE7
  assign flush.rx_abort = (bit_mismatch_event && state_reg.ext.rx_abort_on_bit_error) ||
                          state_reg.ext.fifo_flush; // RULE6 RULE7
  assign flush.fifo_flush = state_reg.ext.fifo_flush;

  always_comb begin
    state_next = state_reg;
    state_next.ext.fifo_flush = 1'b0; // RULE7
    state_next.tx_line = tx_bit;
    state_next.tx_pin = tx_bit ^ state_reg.ext.tx_output_polarity;
    // The receiver sees the transmit line instead of the pin in loopback.
    state_next.rx_line = state_reg.ext.loopback_enable_bit ? state_reg.tx_line
                                                            : rx_synced; // RULE4
    if (setup_phase) begin
      state_next.prdata = read_value;
      state_next.pslverr = !addr_hit(apb_req.paddr);
    end
    if (write_done) begin
      if (apb_req.paddr == byte_addr(LINE_CFG_IDX)) begin
        state_next.line_cfg = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == byte_addr(EXT_CFG_IDX)) begin
        if (!apb_req.pwdata[EXT_MISMATCH]) begin
          state_next.ext.bit_mismatch_flag = 1'b0;
        end
        state_next.ext.tx_abort_on_bit_error = apb_req.pwdata[EXT_TX_ABORT];
        state_next.ext.rx_abort_on_bit_error = apb_req.pwdata[EXT_RX_ABORT];
        state_next.ext.loopback_enable_bit = apb_req.pwdata[EXT_LOOPBACK];
        state_next.ext.bit_error_irq_enable = apb_req.pwdata[EXT_IRQ_EN];
        state_next.ext.fifo_flush = apb_req.pwdata[EXT_FLUSH]; // RULE7
        state_next.ext.tx_output_polarity = apb_req.pwdata[EXT_POLARITY];
      end else if (apb_req.paddr == byte_addr(IRQ_STAT_IDX)) begin
        state_next.irq_status = state_reg.irq_status & ~apb_req.pwdata[IRQ_W-1:0];
      end else if (apb_req.paddr == byte_addr(IRQ_MASK_IDX)) begin
        state_next.irq_mask = apb_req.pwdata[IRQ_W-1:0];
      end
    end
    // Hardware events win over a clear in the same cycle.
    if (bit_mismatch_event) begin
      state_next.ext.bit_mismatch_flag = 1'b1; // RULE3
      state_next.irq_status[IRQ_BIT_ERR] = 1'b1;
    end
    case (state_reg.rx_state)
      RX_IDLE: begin
        if (rx_start_det) begin
          state_next.rx_state = RX_ACTIVE; // RULE1
          state_next.irq_status[IRQ_RX_START] = 1'b1;
        end
      end
      RX_ACTIVE: begin
        if (rx_stop_det) begin
          state_next.rx_state = RX_IDLE; // RULE2
          state_next.irq_status[IRQ_RX_DONE] = 1'b1;
        end
      end
      default: begin
        state_next.rx_state = RX_IDLE;
      end
    endcase
    // A receive reset ends the frame in progress.
    if (flush.rx_abort) begin
      state_next.rx_state = RX_IDLE; // RULE6
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CTL_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.prdata = state_reg.prdata;
  assign apb_rsp.pslverr = state_reg.pslverr;
  assign rx_line = state_reg.rx_line;
  assign tx_pin = state_reg.tx_pin;
  assign line_config = state_reg.line_cfg;
  assign receive_in_progress = (state_reg.rx_state == RX_ACTIVE);
  assign irq = |(state_reg.irq_status & state_reg.irq_mask &
                 {{(IRQ_W-1){1'b1}}, state_reg.ext.bit_error_irq_enable});

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_start_sets_busy: assert property ( // RULE1
    (!receive_in_progress && rx_start_det && !flush.rx_abort) |=> receive_in_progress)
    else $error("Start bit did not set the receive flag.");

  a_stop_clears_busy: assert property ( // RULE2
    (receive_in_progress && rx_stop_det) |=> !receive_in_progress)
    else $error("Stop condition did not clear the receive flag.");

  a_tx_abort_now: assert property ( // RULE3
    (bit_mismatch_event && state_reg.ext.tx_abort_on_bit_error) |-> flush.tx_abort)
    else $error("Transmit abort missing on bit mismatch.");

  a_mismatch_flag_set: assert property ( // RULE3
    bit_mismatch_event |=> state_reg.ext.bit_mismatch_flag [*1] ##0 state_reg.irq_status[0])
    else $error("Bit mismatch did not set its flags.");

  a_loopback_route: assert property ( // RULE4
    (state_reg.ext.loopback_enable_bit && !write_done) |=> (rx_line == $past(state_reg.tx_line)))
    else $error("Loopback did not route the transmit line.");

  a_rx_abort_now: assert property ( // RULE6
    (bit_mismatch_event && state_reg.ext.rx_abort_on_bit_error) |-> flush.rx_abort ##1
    !receive_in_progress)
    else $error("Receive abort missing on bit mismatch.");

  a_flush_pulse: assert property ( // RULE7
    (write_done && apb_req.paddr == byte_addr(EXT_CFG_IDX) && apb_req.pwdata[EXT_FLUSH])
    |=> (flush.fifo_flush && flush.tx_abort && flush.rx_abort) ##1 !flush.fifo_flush)
    else $error("Flush bit did not pulse and self-clear.");

  a_irq_masked: assert property (
    (state_reg.irq_mask == '0) |-> !irq)
    else $error("Interrupt raised with all sources masked.");

  a_unmapped_error: assert property (
    (setup_phase && !addr_hit(apb_req.paddr)) |=> apb_rsp.pslverr)
    else $error("Unmapped access not answered with an error.");

  a_tx_abort_quiet: assert property ( // RULE3
    (!bit_mismatch_event && !state_reg.ext.fifo_flush) |-> !flush.tx_abort)
    else $error("Transmit abort raised without a cause.");

  a_rx_abort_quiet: assert property ( // RULE6
    (!bit_mismatch_event && !state_reg.ext.fifo_flush) |-> !flush.rx_abort)
    else $error("Receive abort raised without a cause.");

  a_busy_holds_idle: assert property ( // RULE1
    (!receive_in_progress && !rx_start_det) |=> !receive_in_progress)
    else $error("Receive flag set without a start bit.");

  a_busy_holds_active: assert property ( // RULE2
    (receive_in_progress && !rx_stop_det && !flush.rx_abort) |=> receive_in_progress)
    else $error("Receive flag dropped without a stop condition.");

  a_start_status: assert property ( // RULE1
    (!receive_in_progress && rx_start_det) |=> state_reg.irq_status[IRQ_RX_START])
    else $error("Start bit did not set its status bit.");

  a_stop_status: assert property ( // RULE2
    (receive_in_progress && rx_stop_det) |=> state_reg.irq_status[IRQ_RX_DONE])
    else $error("Stop condition did not set its status bit.");

  a_flush_self_clear: assert property ( // RULE7
    (flush.fifo_flush && !write_done) |=> !flush.fifo_flush)
    else $error("Flush request did not clear itself.");

  a_loop_off_route: assert property ( // RULE4
    !state_reg.ext.loopback_enable_bit |=> (rx_line == $past(rx_synced)))
    else $error("Receive line did not follow the pin.");

  a_loop_enable_write: assert property ( // RULE4
    (write_done && apb_req.paddr == byte_addr(EXT_CFG_IDX)) |=>
    (state_reg.ext.loopback_enable_bit == $past(apb_req.pwdata[EXT_LOOPBACK])))
    else $error("Loopback enable not written.");

  a_tx_pin_polarity: assert property (
    1'b1 |=> (tx_pin == ($past(tx_bit) ^ $past(state_reg.ext.tx_output_polarity))))
    else $error("Transmit pin does not follow bit and polarity.");

  a_mismatch_flag_hold: assert property ( // RULE3
    (state_reg.ext.bit_mismatch_flag && !write_done) |=> state_reg.ext.bit_mismatch_flag)
    else $error("Bit mismatch flag lost without a write.");

  a_irq_bit_err: assert property (
    (state_reg.irq_status[IRQ_BIT_ERR] && state_reg.irq_mask[IRQ_BIT_ERR] &&
     state_reg.ext.bit_error_irq_enable) |-> irq)
    else $error("Unmasked bit error did not raise the interrupt.");

  a_irq_enable_gate: assert property (
    (!state_reg.ext.bit_error_irq_enable &&
     state_reg.irq_mask[IRQ_RX_DONE:IRQ_RX_START] == '0) |-> !irq)
    else $error("Interrupt raised with bit error reporting disabled.");

  a_stat_w1c: assert property (
    (write_done && apb_req.paddr == byte_addr(IRQ_STAT_IDX) && apb_req.pwdata[IRQ_RX_DONE] &&
     !(receive_in_progress && rx_stop_det)) |=> !state_reg.irq_status[IRQ_RX_DONE])
    else $error("Status bit not cleared by writing one.");

  a_mapped_no_error: assert property (
    (setup_phase && addr_hit(apb_req.paddr)) |=> !apb_rsp.pslverr)
    else $error("Mapped access answered with an error.");

  a_unmapped_read_zero: assert property (
    (setup_phase && !addr_hit(apb_req.paddr)) |=> (apb_rsp.prdata == '0))
    else $error("Unmapped read returned nonzero data.");

  a_line_write: assert property (
    (write_done && apb_req.paddr == byte_addr(LINE_CFG_IDX)) |=>
    (line_config == $past(apb_req.pwdata[7:0])))
    else $error("Line configuration write lost.");

  a_setup_line_data: assert property (
    (setup_phase && apb_req.paddr == byte_addr(LINE_CFG_IDX)) |=>
    (apb_rsp.prdata[7:0] == $past(state_reg.line_cfg)))
    else $error("Line configuration read data wrong.");

  a_prdata_holds: assert property (
    !setup_phase |=> $stable(apb_rsp.prdata))
    else $error("Read data changed outside a setup cycle.");

  a_mask_write: assert property (
    (write_done && apb_req.paddr == byte_addr(IRQ_MASK_IDX)) |=>
    (state_reg.irq_mask == $past(apb_req.pwdata[IRQ_W-1:0])))
    else $error("Interrupt mask write lost.");

  c_frame_seen: cover property (rx_start_det && !receive_in_progress ##[1:300] rx_stop_det);
  c_abort_both: cover property (flush.tx_abort && flush.rx_abort && bit_mismatch_event);
  c_loopback_mismatch: cover property (state_reg.ext.loopback_enable_bit && bit_mismatch_event);
  c_flush_seen: cover property (flush.fifo_flush);
  c_irq_raised: cover property ($rose(irq));

endmodule : uart_ext_config_bit_mismatch_event

// [hdl/uart_ext_pkg.sv]
// Shared constants and types for the extended serial configuration block.
package uart_ext_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] LINE_CFG_IDX = 12'h0B1;
  localparam logic [ADDR_W-1:0] EXT_CFG_IDX = 12'h0B2;
  localparam logic [ADDR_W-1:0] IRQ_STAT_IDX = 12'h0B6;
  localparam logic [ADDR_W-1:0] IRQ_MASK_IDX = 12'h0B7;

  // Extended configuration field positions.
  localparam int unsigned EXT_RX_BUSY = 7;
  localparam int unsigned EXT_MISMATCH = 6;
  localparam int unsigned EXT_TX_ABORT = 5;
  localparam int unsigned EXT_RX_ABORT = 4;
  localparam int unsigned EXT_LOOPBACK = 3;
  localparam int unsigned EXT_IRQ_EN = 2;
  localparam int unsigned EXT_FLUSH = 1;
  localparam int unsigned EXT_POLARITY = 0;

  // Interrupt status and mask field positions.
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_BIT_ERR = 0;
  localparam int unsigned IRQ_RX_START = 1;
  localparam int unsigned IRQ_RX_DONE = 2;

  // Synchroniser depth for pin inputs.
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_ACTIVE = 1'b1
  } rx_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic [DATA_W-1:0] prdata;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic bit_mismatch_flag;
    logic tx_abort_on_bit_error;
    logic rx_abort_on_bit_error;
    logic loopback_enable_bit;
    logic bit_error_irq_enable;
    logic fifo_flush;
    logic tx_output_polarity;
  } ext_cfg_t;

  typedef struct packed {
    logic tx_abort;
    logic rx_abort;
    logic fifo_flush;
  } flush_ctl_t;

  typedef struct packed {
    logic [7:0] line_cfg;
    ext_cfg_t ext;
    rx_state_t rx_state;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic tx_line;
    logic tx_pin;
    logic rx_line;
    logic [DATA_W-1:0] prdata;
    logic pslverr;
  } ctl_state_t;

  // Every register of the block clears to zero.
  localparam ctl_state_t CTL_STATE_RST = '0;

endpackage : uart_ext_pkg

// [hdl/pin_sync.sv]
// Two-flop synchroniser for a pin that arrives from outside the clock domain.
`timescale 1ns/1ps
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_async,
  output logic pin_synced
);
  import uart_ext_pkg::*;

  logic [SYNC_STAGES-1:0] chain_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= {chain_reg[SYNC_STAGES-2:0], pin_async};
    end
  end

  assign pin_synced = chain_reg[SYNC_STAGES-1];

endmodule : pin_sync

// [hdl/bit_checker.sv]
// Compares each transmitted bit with the level seen on the receive input.
`timescale 1ns/1ps
module bit_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic check_valid,
  input wire logic expect_bit,
  input wire logic seen_bit,
  output logic mismatch
);

  logic mismatch_reg;

  // A one-cycle pulse follows every strobe whose bit was read back wrong.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mismatch_reg <= 1'b0;
    end else begin
      mismatch_reg <= check_valid && (expect_bit != seen_bit);
    end
  end

  assign mismatch = mismatch_reg;

endmodule : bit_checker

// [bench/serial_peer.sv]
// Remote serial node model that drives the receive pin of the block.
`timescale 1ns/1ps
module serial_peer (
  input wire logic hold_low,
  input wire logic tx_pin,
  input wire logic pin_function_select,
  output logic rx_pin,
  output logic line_level
);
  // The line rests at the mark level and is pulled low only on command.
  assign rx_pin = hold_low ? 1'b0 : 1'b1;
  // A deselected transmit pin leaves the peer's line at its pull-up level.
  assign line_level = pin_function_select ? tx_pin : 1'b1;
endmodule : serial_peer

// [bench/uart_ext_config_bit_mismatch_event_test.sv]
// Self-checking testbench for the extended serial configuration block.
`timescale 1ns/1ps
module uart_ext_config_bit_mismatch_event_test;
  import uart_ext_pkg::*;
  localparam logic [11:0] A_LINE = LINE_CFG_IDX << 2;
  localparam logic [11:0] A_EXT = EXT_CFG_IDX << 2;
  localparam logic [11:0] A_STAT = IRQ_STAT_IDX << 2;
  localparam logic [11:0] A_MASK = IRQ_MASK_IDX << 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic rx_pin, tx_bit = 1'b0, tx_check_valid = 1'b0, tx_check_bit = 1'b0;
  logic rx_start_det = 1'b0, rx_stop_det = 1'b0, hold_low = 1'b0;
  logic pin_function_select = 1'b1;
  logic line_level;
  logic rx_line, tx_pin, receive_in_progress, irq;
  flush_ctl_t flush;
  logic [7:0] line_config;
  logic [31:0] q;
  logic e;
  int n_fail = 0;
  int num_checks = 0;

  always #2.5 pclk = ~pclk;

  serial_peer u_serial_peer (
    .hold_low(hold_low), .tx_pin(tx_pin), .pin_function_select(pin_function_select),
    .rx_pin(rx_pin), .line_level(line_level));

  uart_ext_config_bit_mismatch_event u_uart_ext_config_bit_mismatch_event (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .rx_pin(rx_pin),
    .tx_bit(tx_bit), .tx_check_valid(tx_check_valid), .tx_check_bit(tx_check_bit),
    .rx_start_det(rx_start_det), .rx_stop_det(rx_stop_det), .rx_line(rx_line),
    .tx_pin(tx_pin), .flush(flush), .line_config(line_config),
    .receive_in_progress(receive_in_progress), .irq(irq));

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask : rdc

  task automatic pulse_rx(input logic st);
    @(posedge pclk);
    if (st) rx_start_det <= 1'b1;
    else rx_stop_det <= 1'b1;
    @(posedge pclk);
    rx_start_det <= 1'b0;
    rx_stop_det <= 1'b0;
    @(negedge pclk);
  endtask : pulse_rx

  task automatic miss();
    @(posedge pclk);
    tx_check_valid <= 1'b1;
    tx_check_bit <= 1'b0;
    @(posedge pclk);
    tx_check_valid <= 1'b0;
    @(negedge pclk);
  endtask : miss

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc("line reset", A_LINE, 32'h0);
    rdc("ext reset", A_EXT, 32'h0);
    apb(1'b1, A_LINE, 32'h0000_00A5);
    rdc("line rw", A_LINE, 32'h0000_00A5);
    chk("line out", line_config, 32'h0000_00A5);
    rdc("unmapped data", 12'h000, 32'h0);
    chk("unmapped err", e, 1'b1);
    $display("test registers done");
    pulse_rx(1'b1);
    chk("rx busy set", receive_in_progress, 1'b1);
    rdc("ext busy", A_EXT, 32'h0000_0080);
    pulse_rx(1'b0);
    chk("rx busy clear", receive_in_progress, 1'b0);
    rdc("status", A_STAT, 32'h0000_0006);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, A_MASK, 32'h0000_0006);
    @(negedge pclk);
    chk("irq on", irq, 1'b1);
    apb(1'b1, A_STAT, 32'h0000_0006);
    @(negedge pclk);
    chk("irq cleared", irq, 1'b0);
    $display("test receive status done");
    apb(1'b1, A_MASK, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_EXT, {26'h0, i[1], i[0], 4'h4});
      pulse_rx(1'b1);
      miss();
      chk("tx abort", flush.tx_abort, i[1]);
      chk("rx abort", flush.rx_abort, i[0]);
      @(negedge pclk);
      chk("tx abort end", flush.tx_abort, 1'b0);
      chk("rx busy abort", receive_in_progress, !i[0]);
      chk("irq bit error", irq, 1'b1);
      rdc("ext flag", A_EXT, {24'h0, !i[0], 1'b1, i[1], i[0], 4'h4});
      pulse_rx(1'b0);
      apb(1'b1, A_STAT, 32'h0000_0007);
    end
    $display("test bit error done");
    apb(1'b1, A_EXT, 32'h0000_0002);
    @(negedge pclk);
    chk("flush pulse", flush, 3'b111);
    @(negedge pclk);
    chk("flush end", flush, 3'b000);
    rdc("flush self clear", A_EXT, 32'h0);
    $display("test flush done");
    // Software keeps the pin function deselected while looping back.
    pin_function_select <= 1'b0;
    apb(1'b1, A_EXT, 32'h0000_0008);
    hold_low <= 1'b0;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("loop low", rx_line, 1'b0);
    chk("line quiet", line_level, 1'b1);
    @(posedge pclk);
    tx_bit <= 1'b1;
    hold_low <= 1'b1;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("loop high", rx_line, 1'b1);
    chk("tx pin", tx_pin, 1'b1);
    apb(1'b1, A_EXT, 32'h0000_0001);
    pin_function_select <= 1'b1;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("pin path", rx_line, 1'b0);
    chk("tx pin inverted", tx_pin, 1'b0);
    chk("line driven", line_level, 1'b0);
    $display("test loopback done");
    report_and_stop();
  end
endmodule : uart_ext_config_bit_mismatch_event_test
